// File: dv/hlc_mgmt_host.sv
`timescale 1ns/1ps
`include "hlc_map.svh"
module hlc_mgmt_host import hlc_pkg::*; (
  input  wire logic        clock_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output hlc_mgmt_req_t    req_out
);
  initial req_out = '0;

  // Released lines show inverted values so stale data never looks valid
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'hffff};
    #1;
    data = (rvalid_in === 1'b1) ? rdata_in : 16'hxxxx;
  endtask

  // Pointer always goes first
  task automatic write_ext(input logic [15:0] addr, input logic [15:0] data);
    write_reg(`HLC_REG_EXT_PTR, addr);
    write_reg(`HLC_REG_EXT_DATA, data);
  endtask

  task automatic read_ext(input logic [15:0] addr, output logic [15:0] data);
    write_reg(`HLC_REG_EXT_PTR, addr);
    read_reg(`HLC_REG_EXT_DATA, data);
  endtask
endmodule

// File: dv/test_hs_lane_control_and_indirect_access.sv
`timescale 1ns/1ps
`include "hlc_map.svh"
module test_hs_lane_control_and_indirect_access import hlc_pkg::*; ();
  logic          clock_in;
  logic          resetn_in;
  hlc_mgmt_req_t mgmt_req;
  logic [15:0]   rdata;
  logic          rvalid;
  logic          tx_valid_in, tx_valid_out, rx_valid_in, rx_valid_out;
  logic [9:0]    tx_raw_in, tx_coded_in, tx_word_out;
  logic [9:0]    rx_raw_in, rx_decoded_in, rx_word_out;
  logic          rx_code_err_in, rx_comma_in, jog_step_in, sync_out;
  logic [3:0]    rx_align_in, align_pos_out;
  logic [2:0]    rx_depth, tx_depth;
  int            n_mismatch = 0;
  int            checks_done = 0;

  hlc_mgmt_host hlc_mgmt_host_inst (.clock_in(clock_in), .rdata_in(rdata),
    .rvalid_in(rvalid), .req_out(mgmt_req));

  hlc_lane_ctrl hlc_lane_ctrl_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .mgmt_req_in(mgmt_req), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
    .tx_valid_in(tx_valid_in), .tx_raw_in(tx_raw_in), .tx_coded_in(tx_coded_in),
    .tx_valid_out(tx_valid_out), .tx_word_out(tx_word_out), .rx_valid_in(rx_valid_in),
    .rx_raw_in(rx_raw_in), .rx_decoded_in(rx_decoded_in), .rx_code_err_in(rx_code_err_in),
    .rx_comma_in(rx_comma_in), .rx_align_in(rx_align_in), .jog_step_in(jog_step_in),
    .rx_valid_out(rx_valid_out), .rx_word_out(rx_word_out), .sync_out(sync_out),
    .align_pos_out(align_pos_out), .fast_receive_buffer_depth_out(rx_depth),
    .fast_transmit_buffer_depth_out(tx_depth));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    hlc_mgmt_host_inst.write_reg(a, d);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e, input string w);
    logic [15:0] d;
    hlc_mgmt_host_inst.read_reg(a, d);
    check(d, e, w);
  endtask

  task automatic echk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    hlc_mgmt_host_inst.read_ext(a, d);
    check(d, e, "extended read");
  endtask

  // Same word pair into both paths, both outputs judged one cycle later
  task automatic lane(input logic [9:0] raw, coded, exp_tx, exp_rx);
    @(posedge clock_in);
    {tx_valid_in, rx_valid_in} <= 2'b11;
    {tx_raw_in, rx_raw_in, tx_coded_in, rx_decoded_in} <= {raw, raw, coded, coded};
    @(posedge clock_in);
    {tx_valid_in, rx_valid_in} <= 2'b00;
    #1;
    check(16'({tx_valid_out, rx_valid_out}), 16'h0003, "valid");
    check(16'(tx_word_out), 16'(exp_tx), "tx word");
    check(16'(rx_word_out), 16'(exp_rx), "rx word");
  endtask

  // One word per edge; the next edge samples it, so calls in a row are adjacent
  task automatic sym(input logic comma, input logic err);
    @(posedge clock_in);
    rx_valid_in <= 1'b1;
    {rx_comma_in, rx_code_err_in} <= {comma, err};
  endtask

  // Lets the last word be sampled, then idles the lane before a look
  task automatic idle;
    @(posedge clock_in);
    rx_valid_in <= 1'b0;
    #1;
  endtask

  task automatic test_reset_values;
    rchk(`HLC_REG_LANE_CTRL, 16'h0880, "control reset");
    rchk(`HLC_REG_EXT_PTR, 16'h0000, "pointer reset");
    check(16'({rx_depth, tx_depth}), 16'h0000, "depth reset");
    rchk(5'h03, 16'h0000, "unmapped");
    echk(16'h8000, 16'h02bc);
    echk(16'h8001, 16'h027c);
    echk(16'h8002, 16'h027c);
    echk(16'h8003, 16'h02bc);
    echk(16'h8004, 16'h0000);
    rchk(`HLC_REG_EXT_PTR, 16'h8004, "pointer");
    $display("test reset_values done");
  endtask

  task automatic test_depths;
    wreg(`HLC_REG_LANE_CTRL, 16'hdb80);
    repeat (2) @(posedge clock_in);
    #1;
    check(16'(rx_depth), 16'h0005, "rx depth");
    check(16'(tx_depth), 16'h0003, "tx depth");
    rchk(`HLC_REG_LANE_CTRL, 16'h5b80, "self clear");
    wreg(`HLC_REG_LANE_CTRL, 16'h0880);
    $display("test depths done");
  endtask

  task automatic test_markers;
    lane(10'h155, 10'h2bc, 10'h27c, 10'h2bc);
    lane(10'h155, 10'h27c, 10'h27c, 10'h2bc);
    lane(10'h155, 10'h0f0, 10'h0f0, 10'h0f0);
    wreg(`HLC_REG_LANE_CTRL, 16'h0800);
    lane(10'h155, 10'h2bc, 10'h2bc, 10'h2bc);
    wreg(`HLC_REG_LANE_CTRL, 16'h0080);
    lane(10'h155, 10'h27c, 10'h27c, 10'h27c);
    wreg(`HLC_REG_LANE_CTRL, 16'h088c);
    lane(10'h155, 10'h2bc, 10'h155, 10'h155);
    wreg(`HLC_REG_LANE_CTRL, 16'h0880);
    hlc_mgmt_host_inst.write_ext(16'h8002, 16'hfd55);
    echk(16'h8002, 16'h0155);
    hlc_mgmt_host_inst.write_ext(16'h8001, 16'h03ff);
    lane(10'h155, 10'h2bc, 10'h3ff, 10'h2bc);
    lane(10'h000, 10'h155, 10'h155, 10'h2bc);
    $display("test markers done");
  endtask

  // Code 00 has no clearing word: one good word does not lower its level
  task automatic test_hys(input logic [1:0] code, input int drop);
    wreg(`HLC_REG_LANE_CTRL, 16'h0880 | 16'(code));
    repeat (3) sym(1'b1, 1'b0);
    idle();
    check(16'(sync_out), 16'h0001, "acquired");
    check(16'(align_pos_out), 16'h0005, "aligner");
    if (code != 2'b00) begin
      repeat (drop - 1) sym(1'b0, 1'b1);
      sym(1'b0, 1'b0);
    end
    repeat (drop - 1) sym(1'b0, 1'b1);
    sym(1'b0, 1'b1);
    #1;
    check(16'(sync_out), 16'h0001, "held");
    idle();
    check(16'(sync_out), 16'h0000, "dropped");
    @(posedge clock_in);
    {rx_valid_in, rx_code_err_in} <= 2'b00;
    $display("test hysteresis %0d done", code);
  endtask

  task automatic step;
    @(posedge clock_in);
    jog_step_in <= 1'b1;
    @(posedge clock_in);
    jog_step_in <= 1'b0;
    #1;
  endtask

  task automatic test_alignment;
    wreg(`HLC_REG_LANE_CTRL, 16'h08a0);
    repeat (2) @(posedge clock_in);
    step();
    check(16'(align_pos_out), 16'h0009, "forced");
    wreg(`HLC_REG_LANE_CTRL, 16'h08b0);
    repeat (2) @(posedge clock_in);
    step();
    check(16'(align_pos_out), 16'h0000, "jog wrap");
    step();
    check(16'(align_pos_out), 16'h0001, "jog step");
    $display("test alignment done");
  endtask

  initial begin
    #(40 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    resetn_in = 1'b0;
    {tx_valid_in, rx_valid_in, rx_code_err_in, rx_comma_in, jog_step_in} = '0;
    {tx_raw_in, tx_coded_in, rx_raw_in, rx_decoded_in} = '0;
    rx_align_in = 4'h5;
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    test_reset_values();
    test_depths();
    test_markers();
    test_hys(2'b00, 4);
    test_hys(2'b01, 1);
    test_hys(2'b10, 2);
    test_hys(2'b11, 3);
    test_alignment();
    final_report();
  end
endmodule

// File: src/hlc_lane_ctrl.sv
`timescale 1ns/1ps
`include "hlc_map.svh"
module hlc_lane_ctrl import hlc_pkg::*; (
  input  wire logic          clock_in,
  input  wire logic          resetn_in,
  input  wire hlc_mgmt_req_t mgmt_req_in,
  output logic [15:0]        mgmt_rdata_out,
  output logic               mgmt_rvalid_out,
  input  wire logic          tx_valid_in,
  input  wire logic [9:0]    tx_raw_in,
  input  wire logic [9:0]    tx_coded_in,
  output logic               tx_valid_out,
  output logic [9:0]         tx_word_out,
  input  wire logic          rx_valid_in,
  input  wire logic [9:0]    rx_raw_in,
  input  wire logic [9:0]    rx_decoded_in,
  input  wire logic          rx_code_err_in,
  input  wire logic          rx_comma_in,
  input  wire logic [3:0]    rx_align_in,
  input  wire logic          jog_step_in,
  output logic               rx_valid_out,
  output logic [9:0]         rx_word_out,
  output logic               sync_out,
  output logic [3:0]         align_pos_out,
  output logic [2:0]         fast_receive_buffer_depth_out,
  output logic [2:0]         fast_transmit_buffer_depth_out
);

  hlc_ctrl_t   ctrl_reg, ctrl_next;
  logic [15:0] ptr_reg;
  logic [9:0]  tx_search_reg;
  logic [9:0]  tx_replace_reg;
  logic [9:0]  rx_search_reg;
  logic [9:0]  rx_replace_reg;
  logic [3:0]  align_reg, align_next;
  logic [15:0] rdata_reg;
  logic        rvalid_reg;
  logic [2:0]  rx_depth_reg;
  logic [2:0]  tx_depth_reg;

  // Register decode
  wire wr_ctrl = mgmt_req_in.wr && (mgmt_req_in.addr == `HLC_REG_LANE_CTRL);
  wire wr_ptr  = mgmt_req_in.wr && (mgmt_req_in.addr == `HLC_REG_EXT_PTR);
  wire wr_data = mgmt_req_in.wr && (mgmt_req_in.addr == `HLC_REG_EXT_DATA);

  // Extended target chosen by the pointer; unknown targets ignore writes
  wire ext_tx_s = (ptr_reg == `HLC_EXT_TX_SEARCH);
  wire ext_tx_r = (ptr_reg == `HLC_EXT_TX_REPLACE);
  wire ext_rx_s = (ptr_reg == `HLC_EXT_RX_SEARCH);
  wire ext_rx_r = (ptr_reg == `HLC_EXT_RX_REPLACE);

  wire [9:0] ext_char = ext_tx_s ? tx_search_reg :
                        ext_tx_r ? tx_replace_reg :
                        ext_rx_s ? rx_search_reg :
                        ext_rx_r ? rx_replace_reg : 10'h000;
  wire [15:0] ext_rdata = {6'h00, ext_char};

  wire [15:0] rd_value =
    (mgmt_req_in.addr == `HLC_REG_LANE_CTRL) ? ctrl_reg :
    (mgmt_req_in.addr == `HLC_REG_EXT_PTR)   ? ptr_reg :
    (mgmt_req_in.addr == `HLC_REG_EXT_DATA)  ? ext_rdata : 16'h0000;

  // Bit 15 self-clears one cycle after a write sets it
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.self_clear = 1'b0;
    if (wr_ctrl) begin
      ctrl_next = hlc_ctrl_t'(mgmt_req_in.wdata);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= hlc_ctrl_t'(`HLC_CTRL_RESET);
      ptr_reg  <= `HLC_PTR_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_ptr) begin
        ptr_reg <= mgmt_req_in.wdata;
      end
    end
  end

  // Marker characters live behind the extended data register
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_search_reg  <= `HLC_TX_SEARCH_RST;
      tx_replace_reg <= `HLC_TX_REPLACE_RST;
      rx_search_reg  <= `HLC_RX_SEARCH_RST;
      rx_replace_reg <= `HLC_RX_REPLACE_RST;
    end else if (wr_data) begin
      if (ext_tx_s) tx_search_reg <= mgmt_req_in.wdata[9:0];
      if (ext_tx_r) tx_replace_reg <= mgmt_req_in.wdata[9:0];
      if (ext_rx_s) rx_search_reg <= mgmt_req_in.wdata[9:0];
      if (ext_rx_r) rx_replace_reg <= mgmt_req_in.wdata[9:0];
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= mgmt_req_in.rd;
      if (mgmt_req_in.rd) begin
        rdata_reg <= rd_value;
      end
    end
  end

  assign mgmt_rdata_out  = rdata_reg;
  assign mgmt_rvalid_out = rvalid_reg;

  // Depth selects registered so outputs come from flops
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_depth_reg <= 3'h0;
      tx_depth_reg <= 3'h0;
    end else begin
      rx_depth_reg <= ctrl_reg.fast_receive_buffer_depth;
      tx_depth_reg <= ctrl_reg.fast_transmit_buffer_depth;
    end
  end

  assign fast_receive_buffer_depth_out  = rx_depth_reg;
  assign fast_transmit_buffer_depth_out = tx_depth_reg;

  // Codec skip: raw words bypass the external encoder and decoder
  wire [9:0] tx_sel = ctrl_reg.fast_side_encoder_skip ? tx_raw_in : tx_coded_in;
  wire [9:0] rx_sel = ctrl_reg.fast_side_decoder_skip ? rx_raw_in : rx_decoded_in;

  hlc_marker_swap #(
    .W (10)
  ) u_tx_marker (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .valid_in   (tx_valid_in),
    .data_in    (tx_sel),
    .enable_in  (ctrl_reg.tx_marker_en),
    .search_in  (tx_search_reg),
    .replace_in (tx_replace_reg),
    .valid_out  (tx_valid_out),
    .data_out   (tx_word_out)
  );

  hlc_marker_swap #(
    .W (10)
  ) u_rx_marker (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .valid_in   (rx_valid_in),
    .data_in    (rx_sel),
    .enable_in  (ctrl_reg.rx_marker_en),
    .search_in  (rx_search_reg),
    .replace_in (rx_replace_reg),
    .valid_out  (rx_valid_out),
    .data_out   (rx_word_out)
  );

  hlc_sync_fsm u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .valid_in  (rx_valid_in),
    .bad_in    (rx_code_err_in),
    .comma_in  (rx_comma_in),
    .mode_in   (ctrl_reg.sync_loss_hysteresis_code),
    .sync_out  (sync_out)
  );

  // Alignment: jog overrides force; otherwise taken from the aligner
  // only while hunting, so a locked lane never slips position
  wire force_on = ctrl_reg.force_fixed_alignment &&
                  !ctrl_reg.manual_alignment_step_enable;
  wire jog_on   = ctrl_reg.manual_alignment_step_enable;
  wire [3:0] jog_pos = (align_reg >= `HLC_ALIGN_LAST) ? 4'h0 : 4'(align_reg + 4'h1);
  wire hunt = !ctrl_reg.force_fixed_alignment && !jog_on && !sync_out &&
              rx_valid_in && rx_comma_in;

  assign align_next = force_on                ? `HLC_FORCED_ALIGN :
                      (jog_on && jog_step_in) ? jog_pos :
                      hunt                    ? rx_align_in : align_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      align_reg <= 4'h0;
    end else begin
      align_reg <= align_next;
    end
  end

  assign align_pos_out = align_reg;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  rx_depth_a: assert property (
    wr_ctrl |=> ##1 fast_receive_buffer_depth_out == $past(mgmt_req_in.wdata[14:12], 2))
    else $error("receive depth not applied");
  tx_depth_a: assert property (
    wr_ctrl |=> ##1 fast_transmit_buffer_depth_out == $past(mgmt_req_in.wdata[10:8], 2))
    else $error("transmit depth not applied");
  rx_marker_a: assert property (
    rx_valid_in && ctrl_reg.rx_marker_en && rx_sel == rx_search_reg
    |=> rx_valid_out && rx_word_out == $past(rx_replace_reg))
    else $error("receive marker not replaced");
  tx_marker_a: assert property (
    tx_valid_in && ctrl_reg.tx_marker_en && tx_sel == tx_search_reg
    |=> tx_valid_out && tx_word_out == $past(tx_replace_reg))
    else $error("transmit marker not replaced");
  force_align_a: assert property (
    force_on |=> align_pos_out == `HLC_FORCED_ALIGN)
    else $error("forced alignment not 9");
  jog_step_a: assert property (
    jog_on && jog_step_in && align_reg < `HLC_ALIGN_LAST
    |=> align_pos_out == 4'($past(align_reg) + 4'h1))
    else $error("jog did not step alignment");
  enc_skip_a: assert property (
    tx_valid_in && ctrl_reg.fast_side_encoder_skip && !ctrl_reg.tx_marker_en
    |=> tx_word_out == $past(tx_raw_in))
    else $error("encoder skip not raw");
  dec_skip_a: assert property (
    rx_valid_in && ctrl_reg.fast_side_decoder_skip && !ctrl_reg.rx_marker_en
    |=> rx_word_out == $past(rx_raw_in))
    else $error("decoder skip not raw");
  ext_write_a: assert property (
    wr_data && ext_rx_s |=> rx_search_reg == $past(mgmt_req_in.wdata[9:0]))
    else $error("extended write missed target");
  ext_read_a: assert property (
    mgmt_req_in.rd && mgmt_req_in.addr == `HLC_REG_EXT_DATA
    |=> mgmt_rvalid_out && mgmt_rdata_out == $past(ext_rdata))
    else $error("extended read wrong");
  marker_reset_a: assert property (
    $rose(resetn_in) |-> tx_search_reg == `HLC_TX_SEARCH_RST &&
                         rx_replace_reg == `HLC_RX_REPLACE_RST)
    else $error("marker defaults wrong");

  // Register port: pointer, extended misses, answer timing
  ptr_write_a: assert property (
    wr_ptr |=> ptr_reg == $past(mgmt_req_in.wdata))
    else $error("pointer write lost");
  tx_ext_write_a: assert property (
    wr_data && ext_tx_r |=> tx_replace_reg == $past(mgmt_req_in.wdata[9:0]))
    else $error("extended write missed transmit replace");
  ext_miss_a: assert property (
    mgmt_req_in.rd && mgmt_req_in.addr == `HLC_REG_EXT_DATA &&
    !(ext_tx_s || ext_tx_r || ext_rx_s || ext_rx_r) |=> mgmt_rdata_out == 16'h0000)
    else $error("unmapped extended read not zero");
  read_pulse_a: assert property (
    mgmt_rvalid_out == $past(mgmt_req_in.rd))
    else $error("read answer not one cycle after strobe");
  ctrl_readback_a: assert property (
    mgmt_req_in.rd && mgmt_req_in.addr == `HLC_REG_LANE_CTRL
    |=> mgmt_rdata_out[14:12] == $past(ctrl_reg.fast_receive_buffer_depth))
    else $error("receive depth readback wrong");

  // Datapath and aligner: normal paths must stay untouched
  enc_normal_a: assert property (
    tx_valid_in && !ctrl_reg.fast_side_encoder_skip && !ctrl_reg.tx_marker_en
    |=> tx_word_out == $past(tx_coded_in))
    else $error("encoded word not passed");
  dec_normal_a: assert property (
    rx_valid_in && !ctrl_reg.fast_side_decoder_skip && !ctrl_reg.rx_marker_en
    |=> rx_word_out == $past(rx_decoded_in))
    else $error("decoded word not passed");
  tx_pass_a: assert property (
    tx_valid_in && ctrl_reg.tx_marker_en && tx_sel != tx_search_reg
    |=> tx_word_out == $past(tx_sel))
    else $error("transmit word altered without marker");
  rx_pass_a: assert property (
    rx_valid_in && ctrl_reg.rx_marker_en && rx_sel != rx_search_reg
    |=> rx_word_out == $past(rx_sel))
    else $error("receive word altered without marker");
  hunt_align_a: assert property (
    hunt |=> align_pos_out == $past(rx_align_in))
    else $error("aligner position not taken while hunting");
  jog_hold_a: assert property (
    !jog_on && !force_on && !hunt |=> $stable(align_pos_out))
    else $error("alignment moved with jog disabled");

  ext_path_c: cover property (wr_ptr ##[1:4] wr_data ##[1:4] mgmt_req_in.rd);
  force_c: cover property (force_on ##1 align_pos_out == `HLC_FORCED_ALIGN);
  marker_c: cover property (rx_valid_in && ctrl_reg.rx_marker_en && rx_sel == rx_search_reg);
  jog_c: cover property (jog_on && jog_step_in && align_reg == `HLC_ALIGN_LAST);

endmodule

// File: src/hlc_map.svh
`ifndef HLC_MAP_SVH
`define HLC_MAP_SVH

// Management register numbers
`define HLC_REG_LANE_CTRL  5'h1d
`define HLC_REG_EXT_PTR    5'h1e
`define HLC_REG_EXT_DATA   5'h1f

// Reset values
`define HLC_CTRL_RESET     16'h0880
`define HLC_PTR_RESET      16'h0000

// Extended register addresses
`define HLC_EXT_TX_SEARCH  16'h8000
`define HLC_EXT_TX_REPLACE 16'h8001
`define HLC_EXT_RX_SEARCH  16'h8002
`define HLC_EXT_RX_REPLACE 16'h8003

// Marker character defaults
`define HLC_TX_SEARCH_RST  10'h2bc
`define HLC_TX_REPLACE_RST 10'h27c
`define HLC_RX_SEARCH_RST  10'h27c
`define HLC_RX_REPLACE_RST 10'h2bc

// Byte alignment
`define HLC_FORCED_ALIGN   4'h9
`define HLC_ALIGN_LAST     4'h9

// Synchronisation counts and hysteresis codes
`define HLC_ACQ_COMMAS     2'h3
`define HLC_STD_GOOD_RUN   2'h3
`define HLC_STD_ERR_MAX    2'h3
`define HLC_HYS_STANDARD   2'h0

`endif

// File: src/hlc_marker_swap.sv
`timescale 1ns/1ps
module hlc_marker_swap import hlc_pkg::*; #(
  parameter int W = 10
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic         valid_in,
  input  wire logic [W-1:0] data_in,
  input  wire logic         enable_in,
  input  wire logic [W-1:0] search_in,
  input  wire logic [W-1:0] replace_in,
  output logic              valid_out,
  output logic [W-1:0]      data_out
);

  wire         hit = enable_in && (data_in == search_in);
  wire [W-1:0] data_next = hit ? replace_in : data_in;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_out <= 1'b0;
      data_out  <= '0;
    end else begin
      valid_out <= valid_in;
      if (valid_in) begin
        data_out <= data_next;
      end
    end
  end

  swap_hit_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    valid_in && hit |=> data_out == $past(replace_in))
    else $error("marker not replaced");
  swap_pass_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    valid_in && !enable_in |=> data_out == $past(data_in))
    else $error("data altered while marker logic off");

endmodule

// File: src/hlc_pkg.sv
package hlc_pkg;

  // Same bit layout as the lane control register, bit 15 first
  typedef struct packed {
    logic       self_clear;
    logic [2:0] fast_receive_buffer_depth;
    logic       rx_marker_en;
    logic [2:0] fast_transmit_buffer_depth;
    logic       tx_marker_en;
    logic       spare6;
    logic       force_fixed_alignment;
    logic       manual_alignment_step_enable;
    logic       fast_side_encoder_skip;
    logic       fast_side_decoder_skip;
    logic [1:0] sync_loss_hysteresis_code;
  } hlc_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } hlc_mgmt_req_t;

  typedef enum logic {
    HLC_LOS,
    HLC_SYNC
  } hlc_sync_state_t;

endpackage

// File: src/hlc_sync_fsm.sv
`timescale 1ns/1ps
`include "hlc_map.svh"
module hlc_sync_fsm import hlc_pkg::*; (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       valid_in,
  input  wire logic       bad_in,
  input  wire logic       comma_in,
  input  wire logic [1:0] mode_in,
  output logic            sync_out
);

  hlc_sync_state_t state_reg, state_next;
  logic [1:0] acq_reg, acq_next;
  logic [1:0] err_reg, err_next;
  logic [1:0] good_reg, good_next;

  wire bad  = valid_in && bad_in;
  wire good = valid_in && !bad_in;
  wire std_mode = (mode_in == `HLC_HYS_STANDARD);
  // Fast modes: the code value is the number of adjacent errors
  wire fast_drop = bad && (err_reg == 2'(mode_in - 2'h1));
  wire std_drop  = bad && (err_reg == `HLC_STD_ERR_MAX);

  always_comb begin
    state_next = state_reg;
    acq_next   = acq_reg;
    err_next   = err_reg;
    good_next  = good_reg;
    unique case (state_reg)
      HLC_LOS: begin
        if (bad) begin
          acq_next = 2'h0;
        end else if (valid_in && comma_in) begin
          acq_next = 2'(acq_reg + 2'h1);
          if (acq_next == `HLC_ACQ_COMMAS) begin
            state_next = HLC_SYNC;
            acq_next   = 2'h0;
            err_next   = 2'h0;
            good_next  = 2'h0;
          end
        end
      end
      HLC_SYNC: begin
        if (std_mode) begin
          if (std_drop) begin
            state_next = HLC_LOS;
          end else if (bad) begin
            err_next  = 2'(err_reg + 2'h1);
            good_next = 2'h0;
          end else if (good && err_reg != 2'h0) begin
            good_next = 2'(good_reg + 2'h1);
            if (good_reg == `HLC_STD_GOOD_RUN) begin
              err_next  = 2'(err_reg - 2'h1);
              good_next = 2'h0;
            end
          end
        end else begin
          if (fast_drop) begin
            state_next = HLC_LOS;
          end else if (bad) begin
            err_next = 2'(err_reg + 2'h1);
          end else if (good) begin
            err_next = 2'h0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= HLC_LOS;
      acq_reg   <= 2'h0;
      err_reg   <= 2'h0;
      good_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      acq_reg   <= acq_next;
      err_reg   <= err_next;
      good_reg  <= good_next;
    end
  end

  assign sync_out = (state_reg == HLC_SYNC);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  std_one_err_a: assert property (
    sync_out && std_mode && bad && err_reg == 2'h0 |=> sync_out)
    else $error("standard hysteresis dropped on one error");
  single_drop_a: assert property (
    sync_out && mode_in == 2'h1 && bad |=> !sync_out)
    else $error("mode 01 did not drop on one error");
  two_drop_a: assert property (
    sync_out && mode_in == 2'h2 && err_reg == 2'h0 && bad ##1 bad && mode_in == 2'h2
    |=> !sync_out)
    else $error("mode 10 did not drop on two errors");
  two_hold_a: assert property (
    sync_out && mode_in == 2'h2 && err_reg == 2'h0 && bad |=> sync_out)
    else $error("mode 10 dropped on first error");
  three_drop_a: assert property (
    sync_out && mode_in == 2'h3 && err_reg == 2'h0 && bad ##1 (bad && mode_in == 2'h3) [*2]
    |=> !sync_out)
    else $error("mode 11 did not drop on three errors");
  good_clear_a: assert property (
    sync_out && !std_mode && good |=> err_reg == 2'h0)
    else $error("good code did not clear error run");
  sync_seen_c: cover property (sync_out && bad ##1 !sync_out);

endmodule
